// *** rtl/discard_timer_regs.svh ***
// register offsets, field positions, reset values and timing counts of the discard timer
`ifndef DISCARD_TIMER_REGS_SVH
`define DISCARD_TIMER_REGS_SVH
`define BRIDGE_CONTROL_OFFSET 8'h3e
`define BRIDGE_CONTROL_RESET 16'h0000
`define BC_RSVD_HI 15
`define BC_RSVD_LO 12
`define BC_ERR_ENABLE_BIT 11
`define BC_FLAG_BIT 10
`define BC_INTERVAL_SEL_BIT 9
`define BC_PRIMARY_DISCARD_BIT 8
`define LONG_INTERVAL_CYCLES 16'h8000
`define SHORT_INTERVAL_CYCLES 16'h0400
`endif

// *** rtl/discard_timer_pkg.sv ***
// types shared by the discard timer files
package discard_timer_pkg;
    typedef struct packed {
        logic err_enable;
        logic flag;
        logic interval_sel;
    } upper_ctrl_t;

    typedef enum logic [1:0] {
        ERR_SEV_NONFATAL = 2'b01,
        ERR_SEV_FATAL = 2'b10
    } err_sev_t;

    typedef struct packed {
        logic valid;
        err_sev_t severity;
    } err_msg_t;
endpackage

// *** rtl/discard_counter.sv ***
// expiry counter for one waiting delayed completion
`timescale 1ns/1ps
`include "discard_timer_regs.svh"
module discard_counter (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pci_clk_en,
    input wire logic armed,
    input wire logic restart,
    input wire logic [15:0] limit,
    output logic expired
);
    logic [15:0] count_reg;
    logic [15:0] count_next;
    // at or past the end: a shorter interval chosen mid-wait must not wait for a wrap
    wire logic at_limit = (count_reg >= limit - 16'h0001);
    wire logic fire = armed && !restart && pci_clk_en && at_limit;

    assign count_next = (!armed || restart || fire) ? 16'h0000 :
                        pci_clk_en ? count_reg + 16'h0001 : count_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
            expired <= 1'b0;
        end else begin
            count_reg <= count_next;
            expired <= fire;
        end
    end
endmodule

// *** rtl/delayed_txn_discard_timer.sv ***
// upper byte of the bridge control register and the secondary discard timer
`timescale 1ns/1ps
`include "discard_timer_regs.svh"
module delayed_txn_discard_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pci_clk_en,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [1:0] cfg_be,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    input wire logic conventional_mode,
    input wire logic aer_supported,
    input wire logic aer_fatal_sel,
    input wire logic completion_at_head,
    input wire logic master_retried,
    input wire logic txn_retired,
    output logic discard_txn,
    output discard_timer_pkg::err_msg_t err_msg,
    output logic [7:0] lower_ctrl
);
    // ************************************
    // register decode
    // ************************************
    discard_timer_pkg::upper_ctrl_t ctrl_reg;
    discard_timer_pkg::upper_ctrl_t ctrl_next;
    logic [7:0] lower_reg;
    logic waiting_reg;
    logic expired;

    // one place for the two interval lengths, so the select decodes one way only
    function automatic logic [15:0] interval_of(input logic short_sel);
        if (short_sel) begin
            return `SHORT_INTERVAL_CYCLES;
        end else begin
            return `LONG_INTERVAL_CYCLES;
        end
    endfunction

    // fatal only where advanced reporting exists and software asked for it
    function automatic discard_timer_pkg::err_sev_t severity_of(input logic supported,
                                                                input logic fatal_sel);
        if (supported && fatal_sel) begin
            return discard_timer_pkg::ERR_SEV_FATAL;
        end else begin
            return discard_timer_pkg::ERR_SEV_NONFATAL;
        end
    endfunction

    wire logic hit = (cfg_addr == `BRIDGE_CONTROL_OFFSET);
    wire logic wr_lo = cfg_wr && hit && cfg_be[0];
    wire logic wr_hi = cfg_wr && hit && cfg_be[1];
    wire logic clear_flag = wr_hi && cfg_wdata[`BC_FLAG_BIT];
    wire logic [15:0] interval = interval_of(ctrl_reg.interval_sel);

    wire logic [15:0] reg_view = {4'h0, ctrl_reg.err_enable, ctrl_reg.flag,
                                  ctrl_reg.interval_sel, 1'b0, lower_reg};

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_hi) begin
            ctrl_next.err_enable = cfg_wdata[`BC_ERR_ENABLE_BIT];
            ctrl_next.interval_sel = cfg_wdata[`BC_INTERVAL_SEL_BIT];
        end
        if (clear_flag) begin
            ctrl_next.flag = 1'b0;
        end
        if (expired) begin
            ctrl_next.flag = 1'b1;
        end
    end

    // ************************************
    // waiting for the master to retry
    // ************************************
    // a retry or retirement ends the wait; the head signal rearms it next time
    // limitation: a completion that leaves the head unretired keeps the wait armed
    wire logic restart_wait = master_retried || txn_retired;
    wire logic stop_wait = restart_wait || expired;
    wire logic start_wait = completion_at_head && !waiting_reg;

    discard_counter u_counter (
        .clock(clock),
        .rst_n(rst_n),
        .pci_clk_en(pci_clk_en),
        .armed(waiting_reg),
        .restart(restart_wait),
        .limit(interval),
        .expired(expired)
    );

    // severity is only selectable when advanced error reporting exists
    discard_timer_pkg::err_sev_t sev;
    assign sev = severity_of(aer_supported, aer_fatal_sel);
    wire logic send_err = expired && ctrl_reg.err_enable && conventional_mode;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg <= '0;
            lower_reg <= 8'h00;
            waiting_reg <= 1'b0;
            cfg_rdata <= 16'h0000;
            discard_txn <= 1'b0;
            err_msg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            if (wr_lo) begin
                lower_reg <= cfg_wdata[7:0];
            end
            if (stop_wait) begin
                waiting_reg <= 1'b0;
            end else if (start_wait) begin
                waiting_reg <= 1'b1;
            end
            cfg_rdata <= (cfg_rd && hit) ? reg_view : 16'h0000;
            discard_txn <= expired;
            err_msg.valid <= send_err;
            if (send_err) begin
                err_msg.severity <= sev;
            end else begin
                err_msg.severity <= discard_timer_pkg::ERR_SEV_NONFATAL;
            end
        end
    end

    assign lower_ctrl = lower_reg;

    // ************************************
    // checks
    // ************************************
    sequence s_expiry;
        expired ##1 1'b1;
    endsequence

    sequence s_arm;
        completion_at_head && !waiting_reg && !stop_wait;
    endsequence

    sequence s_clear_only;
        clear_flag && !expired;
    endsequence

    // pulses since the wait was armed, kept apart from the expiry counter it checks
    logic [15:0] pulse_count_reg;
    always_ff @(posedge clock) begin
        if (!rst_n || !waiting_reg || restart_wait) begin
            pulse_count_reg <= 16'h0000;
        end else if (pci_clk_en) begin
            pulse_count_reg <= pulse_count_reg + 16'h0001;
        end
    end

    a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_rd && hit |=> cfg_rdata[15:12] == 4'h0 && cfg_rdata[8] == 1'b0)
        else $error("reserved or primary bit read nonzero");
    a_err_sent: assert property (@(posedge clock) disable iff (!rst_n)
        expired && ctrl_reg.err_enable && conventional_mode |=> err_msg.valid)
        else $error("error message missing on expiry");
    a_sev_default: assert property (@(posedge clock) disable iff (!rst_n)
        err_msg.valid && !$past(aer_supported)
        |-> err_msg.severity == discard_timer_pkg::ERR_SEV_NONFATAL)
        else $error("fatal severity without advanced reporting");
    a_no_err_disabled: assert property (@(posedge clock) disable iff (!rst_n)
        !ctrl_reg.err_enable |=> !err_msg.valid)
        else $error("error message sent while disabled");
    a_mode_gate: assert property (@(posedge clock) disable iff (!rst_n)
        !conventional_mode |=> !err_msg.valid)
        else $error("error message outside conventional mode");
    a_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
        s_expiry |-> ctrl_reg.flag && discard_txn)
        else $error("flag or drop missing after expiry");
    a_start_gate: assert property (@(posedge clock) disable iff (!rst_n)
        !waiting_reg |-> !expired)
        else $error("expiry without waiting completion");
    a_retry_reset: assert property (@(posedge clock) disable iff (!rst_n)
        master_retried |=> !expired)
        else $error("expiry right after retry");
    a_interval_val: assert property (@(posedge clock) disable iff (!rst_n)
        expired |-> pulse_count_reg >= $past(interval)
            && pulse_count_reg <= `LONG_INTERVAL_CYCLES)
        else $error("expiry after the wrong number of pulses");
    a_wait_arm: assert property (@(posedge clock) disable iff (!rst_n)
        s_arm |=> waiting_reg)
        else $error("wait not armed with completion at head");
    a_wait_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !waiting_reg && !completion_at_head |=> !waiting_reg)
        else $error("wait armed without completion at head");
    a_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
        s_clear_only |=> !ctrl_reg.flag)
        else $error("flag not cleared by write of one");
    a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        ctrl_reg.flag && !clear_flag |=> ctrl_reg.flag)
        else $error("flag lost without a clear");
    a_drop_once: assert property (@(posedge clock) disable iff (!rst_n)
        discard_txn |=> !discard_txn)
        else $error("drop pulse longer than one cycle");
    a_err_once: assert property (@(posedge clock) disable iff (!rst_n)
        err_msg.valid |=> !err_msg.valid)
        else $error("error message longer than one cycle");
    a_retire_reset: assert property (@(posedge clock) disable iff (!rst_n)
        txn_retired |=> !expired)
        else $error("expiry right after retirement");
    a_sev_fatal: assert property (@(posedge clock) disable iff (!rst_n)
        err_msg.valid && $past(aer_supported) && $past(aer_fatal_sel)
        |-> err_msg.severity == discard_timer_pkg::ERR_SEV_FATAL)
        else $error("fatal severity not used when selected");
    a_primary_zero: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_rd && hit |=> !cfg_rdata[`BC_PRIMARY_DISCARD_BIT])
        else $error("primary discard bit read nonzero");
    a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !(cfg_rd && hit) |=> cfg_rdata == 16'h0000)
        else $error("read data nonzero without a read hit");
endmodule

// *** sim/secondary_master_model.sv ***
// model of a bus master on the secondary side that repeats its delayed request
`timescale 1ns/1ps
module secondary_master_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic head,
    input wire logic [15:0] delay,
    output logic retried
);
    logic [15:0] cnt_reg;
    // a large delay stands for a slow master that misses the expiry
    always_ff @(posedge clock) begin
        if (!rst_n || !head) begin
            cnt_reg <= 16'h0000;
            retried <= 1'b0;
        end else begin
            retried <= (cnt_reg == delay);
            cnt_reg <= (cnt_reg == delay) ? 16'h0000 : cnt_reg + 16'h0001;
        end
    end
endmodule

// *** sim/tb.sv ***
// self-checking bench of the discard timer block
`timescale 1ns/1ps
module tb;
    logic clock, rst_n, pclk, wr, rd, head, retried, conv, sup, fat, discard, ret;
    logic [7:0] addr, low;
    logic [1:0] be;
    logic [15:0] wdata, rdata, dly, v;
    discard_timer_pkg::err_msg_t msg;
    int errors, n_checks, cyc, c, p, npulse;
    logic [31:0] seed = 32'h07a2_22f8;
    logic [31:0] pseed = 32'h07a2_22f8;
    logic [4:0] rows [5] = '{5'h1d, 5'h1f, 5'h14, 5'h18, 5'h0c};
    delayed_txn_discard_timer u_delayed_txn_discard_timer (.clock(clock), .rst_n(rst_n),
        .pci_clk_en(pclk), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr), .cfg_be(be),
        .cfg_wdata(wdata), .cfg_rdata(rdata), .conventional_mode(conv), .aer_supported(sup),
        .aer_fatal_sel(fat), .completion_at_head(head), .master_retried(retried),
        .txn_retired(ret), .discard_txn(discard), .err_msg(msg), .lower_ctrl(low));
    secondary_master_model u_secondary_master_model (.clock(clock), .rst_n(rst_n),
        .head(head), .delay(dly), .retried(retried));
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
        @(posedge clock);
        wr <= w;
        rd <= !w;
        addr <= a;
        be <= b;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // row bits: interval select, enable, conventional, advanced reporting, fatal select
    task expire(input logic [4:0] r);
        int n;
        logic [15:0] w;
        n = r[4] ? 1024 : 32768;
        seed = xs(seed);
        w = {seed[15:12], r[3], 1'b1, r[4], seed[8:0]};
        acc(1'b1, 8'h3e, 2'h3, w);
        conv <= r[2];
        sup <= r[1];
        fat <= r[0];
        acc(1'b0, 8'h3e, 2'h3, 16'h0000);
        chk("ctrl", v, w & 16'h0aff);
        chk("lower", 16'(low), {8'h00, w[7:0]});
        @(posedge clock);
        head <= 1'b1;
        c = 0;
        #1 p = npulse;
        // up to two pulses more than the interval: the arming edge and the output edge
        while (discard !== 1'b1 && c < 2 * n) begin
            @(posedge clock);
            #1 c++;
        end
        chk("wait", 16'(npulse - p >= n && npulse - p <= n + 2), 16'h0001);
        chk("valid", 16'(msg.valid), 16'(r[3] & r[2]));
        if (msg.valid === 1'b1) begin
            chk("sev", 16'(msg.severity), (r[1] & r[0]) ? 16'h0002 : 16'h0001);
        end
        head <= 1'b0;
        acc(1'b0, 8'h3e, 2'h3, 16'h0000);
        chk("flag", 16'(v[10]), 16'h0001);
        acc(1'b1, 8'h3e, 2'h2, 16'h0400);
        acc(1'b0, 8'h3e, 2'h3, 16'h0000);
        chk("clear", 16'(v[10]), 16'h0000);
        $display("test expiry row %h done", r);
    endtask
    task summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // the secondary clock enable is a random pulse train, high seven times in eight
    always @(posedge clock) begin
        cyc++;
        if (pclk === 1'b1) npulse++;
        pseed = xs(pseed);
        pclk <= |pseed[2:0];
        if (cyc == 80000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        {rst_n, wr, rd, conv, sup, fat, head, addr, be, wdata, ret} = '0;
        dly = 16'hffff;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        acc(1'b0, 8'h3e, 2'h3, 16'h0000);
        chk("reset", v, 16'h0000);
        acc(1'b1, 8'h3c, 2'h3, 16'hffff);
        acc(1'b0, 8'h3c, 2'h3, 16'h0000);
        chk("unmapped", v, 16'h0000);
        acc(1'b1, 8'h3e, 2'h1, 16'hffff);
        acc(1'b0, 8'h3e, 2'h3, 16'h0000);
        chk("byte", v, 16'h00ff);
        chk("low", 16'(low), 16'h00ff);
        $display("test registers done");
        for (int i = 0; i < 5; i++) expire(rows[i]);
        acc(1'b1, 8'h3e, 2'h3, 16'h0a00);
        seed = xs(seed);
        @(posedge clock);
        dly <= 16'(seed[8:0]) + 16'h0010;
        head <= 1'b1;
        c = 0;
        repeat (3000) begin
            @(posedge clock);
            #1 if (discard === 1'b1) c++;
        end
        chk("retry", 16'(c), 16'h0000);
        head <= 1'b0;
        $display("test retry done");
        @(posedge clock);
        dly <= 16'hffff;
        head <= 1'b1;
        c = 0;
        for (int k = 1; k <= 3000; k++) begin
            @(posedge clock);
            ret <= (k % 400 == 0);
            #1 if (discard === 1'b1) c++;
        end
        chk("retire", 16'(c), 16'h0000);
        head <= 1'b0;
        $display("test retire done");
        summarize();
    end
endmodule
